// *** design/dual_serial_cfg.svh ***
/*
  Constants for the dual serial port bus decode block: channel offsets,
  address field positions, rate selection codes and divider counts.
  Assumes inclusion by bare name from the design file and the bench.
*/
`ifndef DUAL_SERIAL_CFG_SVH
`define DUAL_SERIAL_CFG_SVH

`define OFS_PORT0_CONTROL_STATUS 2'h0
`define OFS_PORT0_DATA 2'h1
`define OFS_PORT1_CONTROL_STATUS 2'h2
`define OFS_PORT1_DATA 2'h3
`define ADDR_CHAN_BIT 0
`define ADDR_PORT_BIT 1
`define ADDR_BLOCK_LSB 2
`define ADDR_BLOCK_MSB 7
`define STRAP_RESET 6'h00
`define RATE_SEL_RESET 3'h0
`define IRQ_MODE_RESET 2'h0
`define IRQ_ROUTE_RESET 2'h0
// Reference 2.4576 MHz divided down from the 50 MHz clock
`define CLK_HZ 50000000
`define REF_HZ 2457600
// Rate enable tick at 16x the bit rate, counts relative to 50 MHz
`define RATE_DIV_110 16'h6EF7
`define RATE_DIV_150 16'h515B
`define RATE_DIV_300 16'h28AE
`define RATE_DIV_1200 16'h0A2C
`define RATE_DIV_1800 16'h06C8
`define RATE_DIV_2400 16'h0516
`define RATE_DIV_4800 16'h028B
`define RATE_DIV_9600 16'h0146

`endif

// *** design/dual_serial_pkg.sv ***
/*
  Types for the dual serial port bus decode block.
  Assumes dual_serial_cfg.svh supplies numeric constants.
*/
package dual_serial_pkg;
  typedef enum logic [1:0] {
    IRQ_NONE = 2'h0,
    IRQ_VECTORED = 2'h1,
    IRQ_SINGLE = 2'h2
  } irq_mode_e;

  typedef struct packed {
    logic sel0_ctl;
    logic sel0_dat;
    logic sel1_ctl;
    logic sel1_dat;
    logic rd;
    logic wr;
  } chan_sel_s;

  typedef struct packed {
    chan_sel_s sel;
    logic [7:0] rate_ticks;
    logic [15:0] div0;
    logic [15:0] div1;
    logic [15:0] div2;
    logic [15:0] div3;
    logic [15:0] div4;
    logic [15:0] div5;
    logic [15:0] div6;
    logic [15:0] div7;
    logic rate0;
    logic rate1;
    logic shared_irq;
    logic [7:0] vec_irq;
  } state_s;
endpackage

// *** design/dual_serial_port_bus_decode.sv ***
/*
  Bus decode, rate clock routing and interrupt wiring for a two-port
  serial board on an 8-bit processor I/O bus.
  Assumes bus signals synchronous to MCLK_IN; serial cores sit outside
  and consume the channel selects and rate enables and drive the request inputs.
*/
`timescale 1ns/1ps
`include "dual_serial_cfg.svh"

// Operation
// - Block matches when A2..A7 each equal its polarity strap.
// - All straps true-line selects the block at octal 000-003.
// - Even address picks control channel, odd address picks data.
// - Lower address pair is port 0, upper pair is port 1.
// - Eight rate enables: 110 to 9600 baud from fixed division.
// - Port 0 and port 1 each get a dedicated rate output.
// - Each port selects any of the eight rates independently.
// - One interrupt mode at a time: vectored, single line, or none.
// - Separate request inputs for port 0 and port 1, each routable.
// - Single mode merges chosen requests onto the shared output.
module dual_serial_port_bus_decode (
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic IO_INPUT_STATUS_IN,
  input wire logic IO_OUTPUT_STATUS_IN,
  input wire logic [5:0] ADDRESS_POLARITY_STRAPS_IN,
  input wire logic [2:0] PORT0_RATE_SEL_IN,
  input wire logic [2:0] PORT1_RATE_SEL_IN,
  input wire logic [1:0] IRQ_MODE_IN,
  input wire logic [1:0] IRQ_ROUTE_IN,
  input wire logic [2:0] PORT0_VEC_LEVEL_IN,
  input wire logic [2:0] PORT1_VEC_LEVEL_IN,
  input wire logic PORT0_IRQ_REQUEST_IN,
  input wire logic PORT1_IRQ_REQUEST_IN,
  output logic PORT0_CONTROL_SEL_OUT,
  output logic PORT0_DATA_SEL_OUT,
  output logic PORT1_CONTROL_SEL_OUT,
  output logic PORT1_DATA_SEL_OUT,
  output logic CHAN_READ_OUT,
  output logic CHAN_WRITE_OUT,
  output logic PORT0_RATE_CLOCK_OUT,
  output logic PORT1_RATE_CLOCK_OUT,
  output logic SHARED_IRQ_OUTPUT_OUT,
  output logic [7:0] VECTOR_IRQ_OUT
);
  dual_serial_pkg::state_s st_reg;
  dual_serial_pkg::state_s st_next;
  logic io_cycle;
  logic block_hit;
  logic [1:0] offset;
  logic [15:0] lim [8];
  logic [15:0] cnt [8];
  logic [15:0] cnt_next [8];
  localparam int FAST_GAP = 32'(`RATE_DIV_9600);

  assign lim[0] = `RATE_DIV_110;
  assign lim[1] = `RATE_DIV_150;
  assign lim[2] = `RATE_DIV_300;
  assign lim[3] = `RATE_DIV_1200;
  assign lim[4] = `RATE_DIV_1800;
  assign lim[5] = `RATE_DIV_2400;
  assign lim[6] = `RATE_DIV_4800;
  assign lim[7] = `RATE_DIV_9600;
  assign cnt[0] = st_reg.div0;
  assign cnt[1] = st_reg.div1;
  assign cnt[2] = st_reg.div2;
  assign cnt[3] = st_reg.div3;
  assign cnt[4] = st_reg.div4;
  assign cnt[5] = st_reg.div5;
  assign cnt[6] = st_reg.div6;
  assign cnt[7] = st_reg.div7;

  // Memory cycles at a matching address must never touch a channel
  assign io_cycle = IO_INPUT_STATUS_IN | IO_OUTPUT_STATUS_IN;
  // Strap bit 0 picks the true line, so all-true straps give block zero
  assign block_hit = (ADDR_IN[`ADDR_BLOCK_MSB:`ADDR_BLOCK_LSB]
    == ADDRESS_POLARITY_STRAPS_IN) && io_cycle;
  assign offset = ADDR_IN[`ADDR_PORT_BIT:`ADDR_CHAN_BIT];

  always_comb
  begin
    st_next = st_reg;
    // Registered selects: cores see a clean level one cycle late
    st_next.sel.sel0_ctl = block_hit && (offset == `OFS_PORT0_CONTROL_STATUS);
    st_next.sel.sel0_dat = block_hit && (offset == `OFS_PORT0_DATA);
    st_next.sel.sel1_ctl = block_hit && (offset == `OFS_PORT1_CONTROL_STATUS);
    st_next.sel.sel1_dat = block_hit && (offset == `OFS_PORT1_DATA);
    st_next.sel.rd = block_hit && IO_INPUT_STATUS_IN;
    st_next.sel.wr = block_hit && IO_OUTPUT_STATUS_IN;
    // Free-running dividers, one shared time base
    for (int i = 0; i < 8; i++)
    begin
      if (cnt[i] >= lim[i] - 16'h0001)
      begin
        cnt_next[i] = 16'h0000;
        st_next.rate_ticks[i] = 1'b1;
      end
      else
      begin
        cnt_next[i] = cnt[i] + 16'h0001;
        st_next.rate_ticks[i] = 1'b0;
      end
    end
    st_next.div0 = cnt_next[0];
    st_next.div1 = cnt_next[1];
    st_next.div2 = cnt_next[2];
    st_next.div3 = cnt_next[3];
    st_next.div4 = cnt_next[4];
    st_next.div5 = cnt_next[5];
    st_next.div6 = cnt_next[6];
    st_next.div7 = cnt_next[7];
    // Independent rate routing per port
    // One-cycle enable, not a clock, so everything stays in one domain
    st_next.rate0 = st_reg.rate_ticks[PORT0_RATE_SEL_IN];
    st_next.rate1 = st_reg.rate_ticks[PORT1_RATE_SEL_IN];
    st_next.shared_irq = 1'b0;
    st_next.vec_irq = 8'h00;
    case (dual_serial_pkg::irq_mode_e'(IRQ_MODE_IN))
      dual_serial_pkg::IRQ_SINGLE:
      begin
        // Driving this line assumes no other board shares it
        st_next.shared_irq = (IRQ_ROUTE_IN[0] & PORT0_IRQ_REQUEST_IN)
          | (IRQ_ROUTE_IN[1] & PORT1_IRQ_REQUEST_IN);
      end
      dual_serial_pkg::IRQ_VECTORED:
      begin
        // Both ports on one level simply share that line
        if (IRQ_ROUTE_IN[0] && PORT0_IRQ_REQUEST_IN)
          st_next.vec_irq[PORT0_VEC_LEVEL_IN] = 1'b1;
        if (IRQ_ROUTE_IN[1] && PORT1_IRQ_REQUEST_IN)
          st_next.vec_irq[PORT1_VEC_LEVEL_IN] = 1'b1;
      end
      default:
      begin
        // Mode 3 behaves as no interrupt
        st_next.shared_irq = 1'b0;
      end
    endcase
  end

  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign PORT0_CONTROL_SEL_OUT = st_reg.sel.sel0_ctl;
  assign PORT0_DATA_SEL_OUT = st_reg.sel.sel0_dat;
  assign PORT1_CONTROL_SEL_OUT = st_reg.sel.sel1_ctl;
  assign PORT1_DATA_SEL_OUT = st_reg.sel.sel1_dat;
  assign CHAN_READ_OUT = st_reg.sel.rd;
  assign CHAN_WRITE_OUT = st_reg.sel.wr;
  assign PORT0_RATE_CLOCK_OUT = st_reg.rate0;
  assign PORT1_RATE_CLOCK_OUT = st_reg.rate1;
  assign SHARED_IRQ_OUTPUT_OUT = st_reg.shared_irq;
  assign VECTOR_IRQ_OUT = st_reg.vec_irq;

  // Decode checks: selects lag the bus by one cycle
  a_block_decode: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (io_cycle && ADDR_IN[7:2] != ADDRESS_POLARITY_STRAPS_IN) |=>
      !(PORT0_CONTROL_SEL_OUT | PORT0_DATA_SEL_OUT | PORT1_CONTROL_SEL_OUT | PORT1_DATA_SEL_OUT))
    else $error("Select outside configured block");
  a_zero_block: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (ADDRESS_POLARITY_STRAPS_IN == 6'h00 && IO_INPUT_STATUS_IN && ADDR_IN == 8'h00)
      |=> PORT0_CONTROL_SEL_OUT && CHAN_READ_OUT)
    else $error("Address zero not decoded");
  a_data_odd: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (block_hit && ADDR_IN[0]) |=> (PORT0_DATA_SEL_OUT | PORT1_DATA_SEL_OUT))
    else $error("Odd address missed data channel");
  a_port_one: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (block_hit && offset == 2'h2) |=> PORT1_CONTROL_SEL_OUT && !PORT0_CONTROL_SEL_OUT)
    else $error("Offset two not port 1 control");
  a_mem_ignored: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    !io_cycle |=> !(CHAN_READ_OUT | CHAN_WRITE_OUT | PORT0_DATA_SEL_OUT))
    else $error("Memory cycle selected a channel");
  a_port_top: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (block_hit && offset == 2'h3) |=> PORT1_DATA_SEL_OUT && !PORT0_DATA_SEL_OUT)
    else $error("Offset three not port 1 data");
  a_port_zero: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (block_hit && !ADDR_IN[1]) |=> !(PORT1_CONTROL_SEL_OUT | PORT1_DATA_SEL_OUT))
    else $error("Lower pair reached port 1");
  a_ctl_even: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (block_hit && !ADDR_IN[0]) |=> (PORT0_CONTROL_SEL_OUT | PORT1_CONTROL_SEL_OUT))
    else $error("Even address missed control channel");
  a_one_select: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    $onehot0({PORT0_CONTROL_SEL_OUT, PORT0_DATA_SEL_OUT, PORT1_CONTROL_SEL_OUT,
      PORT1_DATA_SEL_OUT}))
    else $error("More than one channel selected");

  // Rate routing checks
  a_rate_route: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    st_reg.rate_ticks[PORT0_RATE_SEL_IN] |=> PORT0_RATE_CLOCK_OUT)
    else $error("Port 0 rate not from chosen tick");
  a_port1_rate: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    !st_reg.rate_ticks[PORT1_RATE_SEL_IN] |=> !PORT1_RATE_CLOCK_OUT)
    else $error("Port 1 rate pulse without chosen tick");
  a_fast_period: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    st_reg.rate_ticks[7] |=> (!st_reg.rate_ticks[7]) [*8])
    else $error("9600 tick too frequent");
  // Upper bound on the fastest period; the check above gives the lower one
  a_tick_return: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    st_reg.rate_ticks[7] |-> ##[1:FAST_GAP] st_reg.rate_ticks[7])
    else $error("9600 tick overdue");

  // Interrupt wiring checks
  a_irq_merge: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (IRQ_MODE_IN == 2'h2 && IRQ_ROUTE_IN[1] && PORT1_IRQ_REQUEST_IN) |=> SHARED_IRQ_OUTPUT_OUT)
    else $error("Port 1 request not merged");
  a_single_zero: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (IRQ_MODE_IN == 2'h2 && IRQ_ROUTE_IN[0] && PORT0_IRQ_REQUEST_IN) |=> SHARED_IRQ_OUTPUT_OUT)
    else $error("Port 0 request not merged");
  a_irq_none: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (IRQ_MODE_IN != 2'h2) |=> !SHARED_IRQ_OUTPUT_OUT)
    else $error("Shared request outside single mode");
  a_vec_level: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (IRQ_MODE_IN == 2'h1 && IRQ_ROUTE_IN[0] && PORT0_IRQ_REQUEST_IN)
      |=> VECTOR_IRQ_OUT[$past(PORT0_VEC_LEVEL_IN)])
    else $error("Port 0 request missing at its level");
  a_vec_quiet: assert property (@(posedge MCLK_IN) disable iff (!RST_N_IN)
    (IRQ_MODE_IN != 2'h1) |=> (VECTOR_IRQ_OUT == 8'h00))
    else $error("Vector request outside vectored mode");
endmodule // dual_serial_port_bus_decode

// *** sim/host_bus_model.sv ***
/*
  Host processor side of the I/O bus: one address with its status per request.
  Assumes the bench samples the decode outputs one cycle after the request.
*/
`timescale 1ns/1ps
module host_bus_model (
  input wire logic clk_in,
  output logic [7:0] addr_out,
  output logic rd_status_out,
  output logic wr_status_out
);
  initial
  begin
    addr_out = 8'hFF;
    rd_status_out = 1'b0;
    wr_status_out = 1'b0;
  end
  // Status rides with the address; both stay driven until idle() releases the bus
  task automatic io_cycle(input logic [7:0] a, input logic [1:0] st);
    @(posedge clk_in);
    addr_out <= a;
    {wr_status_out, rd_status_out} <= st;
    @(posedge clk_in);
    #1;
  endtask
  // Released bus shows the inverse, so a stale address cannot hit
  task automatic idle();
    @(posedge clk_in);
    addr_out <= ~addr_out;
    {wr_status_out, rd_status_out} <= 2'b00;
  endtask
endmodule // host_bus_model

// *** sim/tb_top.sv ***
/*
  Self-checking bench for the dual serial bus decode block.
  Assumes the host model issues one I/O request at a time.
*/
`timescale 1ns/1ps
`include "dual_serial_cfg.svh"
module tb_top;
  logic clk, rst_n, rd, wr, r0, r1, sh;
  logic [7:0] addr, vec;
  logic [5:0] straps;
  wire logic [5:0] sel;
  logic [2:0] sel0, sel1, lvl0, lvl1;
  logic [1:0] mode, route, req;
  int n_mismatch = 0;
  int compares = 0;
  host_bus_model u_host (.clk_in(clk), .addr_out(addr), .rd_status_out(rd),
    .wr_status_out(wr));
  dual_serial_port_bus_decode u_dut (.MCLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr),
    .IO_INPUT_STATUS_IN(rd), .IO_OUTPUT_STATUS_IN(wr), .ADDRESS_POLARITY_STRAPS_IN(straps),
    .PORT0_RATE_SEL_IN(sel0), .PORT1_RATE_SEL_IN(sel1), .IRQ_MODE_IN(mode),
    .IRQ_ROUTE_IN(route), .PORT0_VEC_LEVEL_IN(lvl0), .PORT1_VEC_LEVEL_IN(lvl1),
    .PORT0_IRQ_REQUEST_IN(req[0]), .PORT1_IRQ_REQUEST_IN(req[1]),
    .PORT0_CONTROL_SEL_OUT(sel[5]), .PORT0_DATA_SEL_OUT(sel[4]),
    .PORT1_CONTROL_SEL_OUT(sel[3]), .PORT1_DATA_SEL_OUT(sel[2]), .CHAN_READ_OUT(sel[1]),
    .CHAN_WRITE_OUT(sel[0]), .PORT0_RATE_CLOCK_OUT(r0), .PORT1_RATE_CLOCK_OUT(r1),
    .SHARED_IRQ_OUTPUT_OUT(sh), .VECTOR_IRQ_OUT(vec));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("Compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic dec(input logic [5:0] s, input logic [7:0] a, input logic [1:0] st);
    logic h;
    @(posedge clk);
    straps <= s;
    h = (st != 2'b00) && (a[7:2] == s);
    u_host.io_cycle(a, st);
    check("chan_sel", {10'h000, sel}, {10'h000, h && a[1:0] == 2'h0,
      h && a[1:0] == 2'h1, h && a[1:0] == 2'h2, h && a[1:0] == 2'h3, h && st[0], h && st[1]});
    u_host.idle();
  endtask
  task automatic decode_scen();
    for (int k = 0; k < 4; k++)
      dec(6'h00, 8'(k), 2'b01);
    dec(6'h00, 8'h02, 2'b10);
    dec(6'h00, 8'h04, 2'b01);
    dec(6'h00, 8'h01, 2'b00);
    dec(6'h2A, 8'hAB, 2'b10);
    dec(6'h2A, 8'hAD, 2'b01);
    dec(6'h2A, 8'h2A, 2'b01);
  endtask
  task automatic irq_scen();
    logic [7:0] ve;
    lvl0 <= 3'h5;
    lvl1 <= 3'h2;
    // The shared line has this block as its only driver here
    for (int m = 0; m < 4; m++)
      for (int q = 0; q < 16; q++)
      begin
        @(posedge clk);
        mode <= 2'(m);
        route <= q[1:0];
        req <= q[3:2];
        @(posedge clk);
        #1;
        ve = 8'h00;
        ve[5] = (2'(m) == dual_serial_pkg::IRQ_VECTORED) && q[0] && q[2];
        ve[2] = (2'(m) == dual_serial_pkg::IRQ_VECTORED) && q[1] && q[3];
        check("vector_irq", {8'h00, vec}, {8'h00, ve});
        check("shared_irq", {15'h0000, sh}, {15'h0000, (2'(m) == dual_serial_pkg::IRQ_SINGLE)
          && |(q[1:0] & q[3:2])});
      end
  endtask
  // Both ports watched at once; gap between the first two pulses forgives the phase
  task automatic rate_pair(input logic [2:0] s0, input logic [2:0] s1);
    logic [15:0] d [8];
    int c [2];
    int g [2];
    int n;
    d = '{`RATE_DIV_110, `RATE_DIV_150, `RATE_DIV_300, `RATE_DIV_1200, `RATE_DIV_1800,
      `RATE_DIV_2400, `RATE_DIV_4800, `RATE_DIV_9600};
    c = '{-1, -1};
    g = '{0, 0};
    n = 0;
    @(posedge clk);
    sel0 <= s0;
    sel1 <= s1;
    while ((g[0] == 0 || g[1] == 0) && n < 60000)
    begin
      @(posedge clk);
      #1;
      n++;
      for (int p = 0; p < 2; p++)
      begin
        if (c[p] >= 0)
          c[p]++;
        if (((p == 0) ? r0 : r1) === 1'b1 && g[p] == 0)
        begin
          if (c[p] > 0)
            g[p] = c[p];
          else
            c[p] = 0;
        end
      end
    end
    if (g[0] == 0 || g[1] == 0)
    begin
      n_mismatch++;
      tally_and_finish();
    end
    else
    begin
      check("rate0_period", 16'(g[0]), d[s0]);
      check("rate1_period", 16'(g[1]), d[s1]);
    end
  endtask
  task automatic rate_scen();
    rate_pair(3'h0, 3'h1);
    rate_pair(3'h2, 3'h3);
    rate_pair(3'h4, 3'h5);
    rate_pair(3'h6, 3'h7);
    rate_pair(3'h7, 3'h7);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    rst_n = 1'b0;
    {straps, sel0, sel1, mode, route, lvl0, lvl1, req} = '0;
    repeat (5) @(posedge clk);
    check("reset_out", {sel, sh, vec, r0}, 16'h0000);
    rst_n <= 1'b1;
    decode_scen();
    irq_scen();
    rate_scen();
    tally_and_finish();
  end
endmodule // tb_top
